/* hw/tx_control_hw_config.sv */
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
// How it works
// - status flush write empties status fifo, self-clears
// - data flush write empties data fifo, self-clears
// - full status fifo stalls unless overrun permitted
// - status-full event independent of overrun permit
// - enable bit set: engine sends queued data
// - enable clears itself after requested halt
// - stop finishes current frame, clears on halt
// - stop bit writes ignored while it is set
// - read-only bit mirrors sampled crossover strap
// - tx buffer size in kilobytes, 2 to 14
// - status fifo fixed 512 bytes, rest data
// - receive gets 16KB minus tx allocation
// - media clock source select, reset internal
// - clock source disabled setting also holds tx_run low
// - receive data full four dwords early
module tx_control_hw_config
  import txcfg_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_crossover_strap,
  input  wire logic        i_frame_active,
  input  wire logic        i_status_fifo_full,
  output logic             o_tx_run,
  output logic             o_status_flush,
  output logic             o_data_flush,
  output logic             o_status_full_event,
  output logic [1:0]       o_media_clock_source,
  output logic [3:0]       o_tx_buffer_size,
  output logic             o_must_be_one_bit,
  output logic [14:0]      o_tx_data_bytes,
  output logic [14:0]      o_rx_total_bytes,
  output logic [14:0]      o_rx_full_bytes
);

  typedef struct packed {
    logic [31:0] rdata;
    logic        strap_meta;
    logic        strap_sync;
    logic        crossover_strap;
    logic        status_overrun_permit;
    logic        tx_enable;
    logic        stop_request;
    logic        status_flush;
    logic        data_flush;
    logic        must_be_one_bit;
    logic [3:0]  tx_buffer_size;
    logic [1:0]  media_clock_source;
    logic        tx_run;
    logic        full_seen;
    logic        status_full_event;
    tx_state_t   tx_state;
  } regs_state_t;

  regs_state_t state_ff;
  regs_state_t nxt_state;
  buf_split_t  split;

  function automatic logic [3:0] clamp_size(input logic [3:0] v);
    if (v < 4'(TX_BUF_MIN_KB)) begin
      clamp_size = 4'(TX_BUF_MIN_KB);
    end else if (v > 4'(TX_BUF_MAX_KB)) begin
      clamp_size = 4'(TX_BUF_MAX_KB);
    end else begin
      clamp_size = v;
    end
  endfunction : clamp_size

  // clock stopped holds tx_run low; the state machine still advances
  function automatic logic clock_usable(input logic [1:0] sel);
    clock_usable = (sel != CLK_DISABLED);
  endfunction : clock_usable

  always_comb begin
    logic wr_tx;
    logic wr_hw;
    logic halted;
    wr_tx = i_wr && (i_addr == TX_CONFIG_OFFSET);
    wr_hw = i_wr && (i_addr == HW_CONFIG_OFFSET);
    nxt_state = state_ff;
    halted = 1'b0;

    // strap passes three flops before use
    nxt_state.strap_meta      = i_crossover_strap;
    nxt_state.strap_sync      = state_ff.strap_meta;
    nxt_state.crossover_strap = state_ff.strap_sync;

    // flush pulses live one cycle
    nxt_state.status_flush = 1'b0;
    nxt_state.data_flush   = 1'b0;

    case (state_ff.tx_state)
      TX_IDLE: begin
        if (state_ff.tx_enable && !state_ff.stop_request) begin
          nxt_state.tx_state = TX_SENDING;
        end else if (state_ff.stop_request) begin
          halted = 1'b1;
        end
      end
      TX_SENDING: begin
        if (state_ff.stop_request || !state_ff.tx_enable) begin
          nxt_state.tx_state = TX_HALTING;
        end
      end
      TX_HALTING: begin
        // current frame finishes before the halt
        if (!i_frame_active) begin
          nxt_state.tx_state = TX_IDLE;
          halted = 1'b1;
        end
      end
      default: begin
        nxt_state.tx_state = TX_IDLE;
      end
    endcase

    if (wr_tx) begin
      nxt_state.status_flush = i_wdata[TX_STATUS_FLUSH_BIT];
      nxt_state.data_flush   = i_wdata[TX_DATA_FLUSH_BIT];
      nxt_state.status_overrun_permit = i_wdata[STATUS_OVERRUN_BIT];
      nxt_state.tx_enable    = i_wdata[TX_ENABLE_BIT];
      if (!state_ff.stop_request) begin
        nxt_state.stop_request = i_wdata[STOP_REQUEST_BIT];
      end
    end

    // halt wins over a same-cycle host write
    if (halted && state_ff.stop_request) begin
      nxt_state.stop_request = 1'b0;
      nxt_state.tx_enable    = 1'b0;
    end

    if (wr_hw) begin
      nxt_state.must_be_one_bit = i_wdata[MUST_BE_ONE_POS];
      nxt_state.tx_buffer_size  =
        clamp_size(i_wdata[TX_BUF_SIZE_LSB +: 4]);
      nxt_state.media_clock_source =
        i_wdata[MEDIA_CLK_LSB +: 2];
    end

    // full stalls sending unless overrun permitted
    nxt_state.tx_run = (nxt_state.tx_state != TX_IDLE) &&
                       clock_usable(state_ff.media_clock_source) &&
                       (!i_status_fifo_full ||
                        state_ff.status_overrun_permit);

    // full event built from fifo only, not the permit bit
    nxt_state.full_seen = i_status_fifo_full;
    nxt_state.status_full_event =
      i_status_fifo_full && !state_ff.full_seen;

    nxt_state.rdata = 32'h0000_0000;
    if (i_rd) begin
      if (i_addr == TX_CONFIG_OFFSET) begin
        // flush bits self-clear so read as zero
        nxt_state.rdata[STATUS_OVERRUN_BIT] =
          state_ff.status_overrun_permit;
        nxt_state.rdata[TX_ENABLE_BIT]      = state_ff.tx_enable;
        nxt_state.rdata[STOP_REQUEST_BIT]   = state_ff.stop_request;
      end else if (i_addr == HW_CONFIG_OFFSET) begin
        nxt_state.rdata[CROSSOVER_STRAP_BIT] = state_ff.crossover_strap;
        nxt_state.rdata[MUST_BE_ONE_POS]     = state_ff.must_be_one_bit;
        nxt_state.rdata[TX_BUF_SIZE_LSB +: 4] = state_ff.tx_buffer_size;
        nxt_state.rdata[MEDIA_CLK_LSB +: 2]  =
          state_ff.media_clock_source;
      end else begin
        nxt_state.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= '0;
      state_ff.tx_buffer_size     <= TX_BUF_SIZE_RESET;
      state_ff.media_clock_source <= MEDIA_CLK_RESET;
      state_ff.tx_state           <= TX_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  buf_split_calc u_split (
    .i_sys_clk     (i_sys_clk),
    .i_rst_n       (i_rst_n),
    .i_tx_buf_size (state_ff.tx_buffer_size),
    .o_split       (split)
  );

  assign o_rdata              = state_ff.rdata;
  assign o_tx_run             = state_ff.tx_run;
  assign o_status_flush       = state_ff.status_flush;
  assign o_data_flush         = state_ff.data_flush;
  assign o_status_full_event  = state_ff.status_full_event;
  assign o_media_clock_source = state_ff.media_clock_source;
  assign o_tx_buffer_size     = state_ff.tx_buffer_size;
  assign o_must_be_one_bit    = state_ff.must_be_one_bit;
  assign o_tx_data_bytes      = split.tx_data_bytes;
  assign o_rx_total_bytes     = split.rx_total_bytes;
  assign o_rx_full_bytes      = split.rx_full_bytes;

  // back-to-back flush writes legally keep the pulse high
  a_flush_status: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_wr && i_addr == TX_CONFIG_OFFSET && i_wdata[TX_STATUS_FLUSH_BIT])
    |=> o_status_flush ##1
        (!o_status_flush || $past(i_wr && i_addr == TX_CONFIG_OFFSET &&
                                  i_wdata[TX_STATUS_FLUSH_BIT])))
    else $error("status flush pulse wrong");

  a_flush_data: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_wr && i_addr == TX_CONFIG_OFFSET && i_wdata[TX_DATA_FLUSH_BIT])
    |=> o_data_flush ##1
        (!o_data_flush || $past(i_wr && i_addr == TX_CONFIG_OFFSET &&
                                i_wdata[TX_DATA_FLUSH_BIT])))
    else $error("data flush pulse wrong");

  a_overrun_stall: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_status_fifo_full && !state_ff.status_overrun_permit) |=> !o_tx_run)
    else $error("ran with full status fifo");

  a_full_event: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_status_fifo_full && !$past(i_status_fifo_full))
    |=> o_status_full_event)
    else $error("status full event missed");

  a_stop_ignored: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (state_ff.stop_request && state_ff.tx_state == TX_SENDING)
    |=> state_ff.stop_request)
    else $error("stop request dropped early");

  a_halt_clears: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (state_ff.tx_state == TX_HALTING && !i_frame_active &&
     state_ff.stop_request)
    |=> (!state_ff.tx_enable && !state_ff.stop_request))
    else $error("halt did not clear enable");

  a_frame_done: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (state_ff.tx_state == TX_HALTING && i_frame_active)
    |=> (state_ff.tx_state == TX_HALTING))
    else $error("halted during a frame");

  a_rx_full: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (o_rx_total_bytes != 15'h0000) |->
      (o_rx_full_bytes == o_rx_total_bytes -
       (o_rx_total_bytes >> RX_STATUS_SHIFT) - RX_FULL_GUARD))
    else $error("rx full margin wrong");

  a_rdata_idle: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_rd |=> (o_rdata == 32'h0000_0000))
    else $error("read data not idle zero");

  a_reserved_tx: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == TX_CONFIG_OFFSET)
    |=> ((o_rdata & 32'hffff_fff8) == 32'h0000_0000))
    else $error("tx config reserved bits set");

  a_reserved_hw: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == HW_CONFIG_OFFSET)
    |=> ((o_rdata & 32'hfee0_ff9f) == 32'h0000_0000))
    else $error("hw config reserved bits set");

  a_clock_off: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (state_ff.media_clock_source == CLK_DISABLED) |=> !o_tx_run)
    else $error("ran with media clock off");

  a_run_state: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    o_tx_run |-> (state_ff.tx_state != TX_IDLE))
    else $error("ran while engine idle");

  a_enable_start: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (state_ff.tx_state == TX_IDLE && state_ff.tx_enable &&
     !state_ff.stop_request) |=> (state_ff.tx_state == TX_SENDING))
    else $error("enabled engine did not start");

  a_size_range: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (o_tx_buffer_size >= 4'(TX_BUF_MIN_KB)) &&
    (o_tx_buffer_size <= 4'(TX_BUF_MAX_KB)))
    else $error("tx buffer size out of range");

  a_strap_read: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_rd && i_addr == HW_CONFIG_OFFSET)
    |=> (o_rdata[CROSSOVER_STRAP_BIT] == $past(state_ff.crossover_strap)))
    else $error("strap bit not mirrored");

  a_stop_write: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (state_ff.stop_request && state_ff.tx_state == TX_SENDING &&
     i_wr && i_addr == TX_CONFIG_OFFSET) |=> state_ff.stop_request)
    else $error("stop bit write not ignored");

  a_clk_write: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_wr && i_addr == HW_CONFIG_OFFSET)
    |=> (o_media_clock_source == $past(i_wdata[MEDIA_CLK_LSB +: 2])))
    else $error("media clock source not written");

endmodule : tx_control_hw_config

/* hw/txcfg_pkg.sv */
package txcfg_pkg;

  // register byte offsets
  localparam logic [7:0] TX_CONFIG_OFFSET = 8'h70;
  localparam logic [7:0] HW_CONFIG_OFFSET = 8'h74;

  // transmit configuration fields
  localparam int TX_STATUS_FLUSH_BIT  = 15;
  localparam int TX_DATA_FLUSH_BIT    = 14;
  localparam int STATUS_OVERRUN_BIT   = 2;
  localparam int TX_ENABLE_BIT        = 1;
  localparam int STOP_REQUEST_BIT     = 0;

  // hardware configuration fields
  localparam int CROSSOVER_STRAP_BIT  = 24;
  localparam int MUST_BE_ONE_POS      = 20;
  localparam int TX_BUF_SIZE_LSB      = 16;
  localparam int MEDIA_CLK_LSB        = 5;

  // reset values
  localparam logic [3:0] TX_BUF_SIZE_RESET = 4'h5;
  localparam logic [1:0] MEDIA_CLK_RESET   = 2'h0;

  // buffer split, in bytes; size limits in kilobytes
  localparam int          TOTAL_BUF_BYTES   = 16384;
  localparam logic [14:0] TX_STATUS_BYTES   = 15'h0200;
  localparam int          TX_BUF_MIN_KB     = 2;
  localparam int          TX_BUF_MAX_KB     = 14;
  localparam logic [14:0] RX_FULL_GUARD     = 15'h0010;
  // receive status takes one sixteenth of the receive share
  localparam int          RX_STATUS_SHIFT   = 4;

  typedef enum logic [1:0] {
    CLK_INTERNAL_A,
    CLK_EXTERNAL,
    CLK_DISABLED,
    CLK_INTERNAL_B
  } media_clk_t;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SENDING,
    TX_HALTING
  } tx_state_t;

  typedef struct packed {
    logic [14:0] tx_total_bytes;
    logic [14:0] tx_data_bytes;
    logic [14:0] rx_total_bytes;
    logic [14:0] rx_full_bytes;
  } buf_split_t;

endpackage : txcfg_pkg

/* hw/buf_split_calc.sv */
`timescale 1ns/10ps
module buf_split_calc
  import txcfg_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic [3:0] i_tx_buf_size,
  output buf_split_t      o_split
);

  typedef struct packed {
    buf_split_t split;
  } calc_state_t;

  calc_state_t state_ff;
  calc_state_t nxt_state;

  always_comb begin
    logic [14:0] tx_total;
    tx_total = {1'b0, i_tx_buf_size, 10'h000};
    nxt_state = state_ff;
    nxt_state.split.tx_total_bytes = tx_total;
    nxt_state.split.tx_data_bytes  = tx_total - TX_STATUS_BYTES;
    nxt_state.split.rx_total_bytes =
      15'(TOTAL_BUF_BYTES) - tx_total;
    // full margin counts from the data part, status share excluded
    nxt_state.split.rx_full_bytes  =
      nxt_state.split.rx_total_bytes -
      (nxt_state.split.rx_total_bytes >> RX_STATUS_SHIFT) -
      RX_FULL_GUARD;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign o_split = state_ff.split;

endmodule : buf_split_calc

/* testbench/testbench.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin \
  n_checks++; \
  if ((a) !== (b)) begin \
    miscompares++; \
    $display("wrong value at %0t: got %h want %h", $time, (a), (b)); \
  end \
end
module testbench;
  import txcfg_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_n;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        i_crossover_strap;
  logic        i_frame_active;
  logic        i_status_fifo_full;
  logic        o_tx_run;
  logic        o_status_flush;
  logic        o_data_flush;
  logic        o_status_full_event;
  logic [1:0]  o_media_clock_source;
  logic [3:0]  o_tx_buffer_size;
  logic        o_must_be_one_bit;
  logic [14:0] o_tx_data_bytes;
  logic [14:0] o_rx_total_bytes;
  logic [14:0] o_rx_full_bytes;
  int          miscompares = 0;
  int          n_checks = 0;
  int          n_sflush = 0;
  int          n_dflush = 0;
  int          n_event = 0;
  logic [31:0] seed;
  logic [31:0] d;
  logic [3:0]  s;
  logic [1:0]  c;
  logic        strap;
  int          k;

  always #4 i_sys_clk = ~i_sys_clk;

  tx_control_hw_config dut_u (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_crossover_strap(i_crossover_strap), .i_frame_active(i_frame_active),
    .i_status_fifo_full(i_status_fifo_full), .o_tx_run(o_tx_run),
    .o_status_flush(o_status_flush), .o_data_flush(o_data_flush),
    .o_status_full_event(o_status_full_event),
    .o_media_clock_source(o_media_clock_source),
    .o_tx_buffer_size(o_tx_buffer_size),
    .o_must_be_one_bit(o_must_be_one_bit),
    .o_tx_data_bytes(o_tx_data_bytes), .o_rx_total_bytes(o_rx_total_bytes),
    .o_rx_full_bytes(o_rx_full_bytes)
  );

  // pulses counted here, so latency choices do not matter
  always @(posedge i_sys_clk) begin
    if (o_status_flush === 1'b1) n_sflush++;
    if (o_data_flush === 1'b1) n_dflush++;
    if (o_status_full_event === 1'b1) n_event++;
  end

  function automatic int clamp_kb(input int v);
    return (v < 2) ? 2 : ((v > 14) ? 14 : v);
  endfunction : clamp_kb

  function automatic logic [14:0] rx_full(input int kb);
    int t;
    t = 16384 - kb * 1024;
    return 15'(t - t / 16 - 16);
  endfunction : rx_full

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    // answer stands until this edge updates it
    @(posedge i_sys_clk);
    v = o_rdata;
  endtask : rd

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    #20000;
    miscompares++;
    complete_run();
  end

  initial begin
    seed = 32'heaec;
    i_rst_n = 1'b0;
    {i_addr, i_wdata, i_wr, i_rd} = '0;
    {i_crossover_strap, i_frame_active, i_status_fifo_full} = '0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    #1 `CHK(o_tx_buffer_size, 4'h5)
    `CHK(o_media_clock_source, 2'h0)
    rd(TX_CONFIG_OFFSET, d);
    `CHK(d, 32'h0)
    rd(HW_CONFIG_OFFSET, d);
    `CHK(d, 32'h00050000)
    // unmapped and reserved bits take no write
    wr(8'h40, 32'hffff_ffff);
    wr(TX_CONFIG_OFFSET, 32'hffff_3ff8);
    rd(8'h40, d);
    `CHK(d, 32'h0)
    rd(TX_CONFIG_OFFSET, d);
    `CHK(d, 32'h0)
    $display("test reset done");
    // corners 0, 2, 14, 15 first, then random sizes; tx is stopped
    for (int i = 0; i < 8; i++) begin
      s = (i < 4) ? 4'(16'hfe20 >> (4 * i)) : 4'($random(seed));
      strap = 1'($random(seed));
      c = 2'(i);
      k = clamp_kb(int'(s));
      i_crossover_strap <= strap;
      wr(HW_CONFIG_OFFSET, {12'hfff, s, 9'h1ff, c, 5'h1f});
      repeat (4) @(posedge i_sys_clk);
      rd(HW_CONFIG_OFFSET, d);
      `CHK(d, {7'h0, strap, 3'h0, 1'b1, k[3:0], 9'h0, c, 5'h0})
      `CHK(o_media_clock_source, c)
      `CHK(o_must_be_one_bit, 1'b1)
      `CHK(o_tx_buffer_size, k[3:0])
      `CHK(o_tx_data_bytes, 15'(k * 1024 - 512))
      `CHK(o_rx_total_bytes, 15'(16384 - k * 1024))
      `CHK(o_rx_full_bytes, rx_full(k))
    end
    wr(HW_CONFIG_OFFSET, 32'h00150000);
    $display("test config done");
    wr(TX_CONFIG_OFFSET, 32'h8000);
    repeat (3) @(posedge i_sys_clk);
    `CHK(n_sflush, 1)
    rd(TX_CONFIG_OFFSET, d);
    `CHK(d, 32'h0)
    wr(TX_CONFIG_OFFSET, 32'h4000);
    repeat (3) @(posedge i_sys_clk);
    `CHK(n_dflush, 1)
    `CHK(n_sflush, 1)
    $display("test flush done");
    i_frame_active <= 1'b1;
    wr(TX_CONFIG_OFFSET, 32'h2);
    repeat (3) @(posedge i_sys_clk);
    `CHK(o_tx_run, 1'b1)
    i_status_fifo_full <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    `CHK(o_tx_run, 1'b0)
    `CHK(n_event, 1)
    i_status_fifo_full <= 1'b0;
    wr(TX_CONFIG_OFFSET, 32'h6);
    repeat (2) @(posedge i_sys_clk);
    i_status_fifo_full <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    `CHK(o_tx_run, 1'b1)
    `CHK(n_event, 2)
    i_status_fifo_full <= 1'b0;
    $display("test overrun done");
    // stop held off by the frame still in flight
    wr(TX_CONFIG_OFFSET, 32'h7);
    repeat (3) @(posedge i_sys_clk);
    `CHK(o_tx_run, 1'b1)
    rd(TX_CONFIG_OFFSET, d);
    `CHK(d, 32'h7)
    wr(TX_CONFIG_OFFSET, 32'h6);
    rd(TX_CONFIG_OFFSET, d);
    `CHK(d, 32'h7)
    i_frame_active <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    `CHK(o_tx_run, 1'b0)
    rd(TX_CONFIG_OFFSET, d);
    `CHK(d, 32'h4)
    $display("test stop done");
    // no media clock: engine enabled yet must not run
    wr(HW_CONFIG_OFFSET, 32'h00150040);
    wr(TX_CONFIG_OFFSET, 32'h2);
    repeat (3) @(posedge i_sys_clk);
    `CHK(o_tx_run, 1'b0)
    `CHK(o_media_clock_source, 2'h2)
    wr(TX_CONFIG_OFFSET, 32'h3);
    repeat (4) @(posedge i_sys_clk);
    rd(TX_CONFIG_OFFSET, d);
    `CHK(d, 32'h0)
    $display("test clock done");
    complete_run();
  end
endmodule : testbench
